// ===== verilog/mcualu_pkg.sv
/*
  Constants and types shared by the instruction datapath block.
  Assumes a single 100 MHz clock and a synchronous active-low reset.
*/
package mcualu_pkg;

  // ---------------------------------------------------------------
  // operation codes from the decoder
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MCUALU_OP_NONE                     = 3'h0,
    MCUALU_OP_COMPLEMENT_TO_ACCUMULATOR = 3'h1,
    MCUALU_OP_DECIMAL_ADJUST           = 3'h2,
    MCUALU_OP_DECREMENT_MEMORY         = 3'h3,
    MCUALU_OP_DECREMENT_TO_ACCUMULATOR = 3'h4,
    MCUALU_OP_INCREMENT_MEMORY         = 3'h5,
    MCUALU_OP_INCREMENT_TO_ACCUMULATOR = 3'h6,
    MCUALU_OP_HALT                     = 3'h7
  } mcualu_op_e;

  // ---------------------------------------------------------------
  // core run state
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    MCUALU_ST_RUN  = 1'h0,
    MCUALU_ST_DOWN = 1'h1
  } mcualu_st_e;

  // ---------------------------------------------------------------
  // widths, reset values and constants
  // ---------------------------------------------------------------
  localparam int         MCUALU_DW          = 8;
  localparam logic [7:0] MCUALU_ACC_RST     = 8'h00;
  localparam logic [3:0] MCUALU_NIB_MAX     = 4'h9;
  localparam logic [7:0] MCUALU_ADJ_LO      = 8'h06;
  localparam logic [7:0] MCUALU_ADJ_HI      = 8'h60;
  localparam logic [7:0] MCUALU_ONE         = 8'h01;
  localparam logic [3:0] MCUALU_LO_LSB      = 4'h0;
  localparam logic [3:0] MCUALU_HI_LSB      = 4'h4;
  localparam logic       MCUALU_FLAG_RST    = 1'b0;

endpackage

// ===== verilog/mcualu_res_if.sv
/*
  Interface carrying one computed result from the arithmetic unit to the core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface mcualu_res_if;
  logic [7:0] value;     // result byte
  logic       to_acc;    // write accumulator
  logic       to_mem;    // write memory
  logic       set_z;     // update zero flag
  logic       z;         // new zero flag
  logic       set_c;     // update carry flag
  logic       c;         // new carry flag
  modport src (output value, to_acc, to_mem, set_z, z, set_c, c);
  modport dst (input  value, to_acc, to_mem, set_z, z, set_c, c);
endinterface // mcualu_res_if

// ===== verilog/mcualu_calc.sv
/*
  Combinational arithmetic for the supported operations.
  Assumes operands are stable while the operation code is presented.
*/
`timescale 1ns/10ps
module mcualu_calc (
  input  wire mcualu_pkg::mcualu_op_e op_i,
  input  wire logic [7:0]             mem_i,
  input  wire logic [7:0]             acc_i,
  input  wire logic                   c_i,
  input  wire logic                   ac_i,
  mcualu_res_if.src                   res
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic nib_high(input logic [3:0] n);
    nib_high = (n > mcualu_pkg::MCUALU_NIB_MAX);
  endfunction

  logic [8:0] sum_lo;
  logic [8:0] sum_all;
  logic       adj_lo;
  logic       adj_hi;

  // decimal adjust correction in two steps
  always_comb begin
    adj_lo  = nib_high(acc_i[3:0]) || ac_i;
    sum_lo  = {1'b0, acc_i} + (adj_lo ? {1'b0, mcualu_pkg::MCUALU_ADJ_LO} : 9'h000);
    adj_hi  = nib_high(sum_lo[7:4]) || c_i || sum_lo[8];
    sum_all = {1'b0, sum_lo[7:0]} + (adj_hi ? {1'b0, mcualu_pkg::MCUALU_ADJ_HI} : 9'h000);
  end

  // result selection per operation
  always_comb begin
    res.value  = mem_i;
    res.to_acc = 1'b0;
    res.to_mem = 1'b0;
    res.set_z  = 1'b0;
    res.set_c  = 1'b0;
    res.c      = c_i;
    case (op_i)
      mcualu_pkg::MCUALU_OP_COMPLEMENT_TO_ACCUMULATOR: begin
        res.value  = ~mem_i;
        res.to_acc = 1'b1;
        res.set_z  = 1'b1;
      end
      mcualu_pkg::MCUALU_OP_DECIMAL_ADJUST: begin
        res.value  = sum_all[7:0];
        res.to_mem = 1'b1;
        res.set_c  = 1'b1;
        res.c      = c_i | adj_hi | sum_all[8];
      end
      mcualu_pkg::MCUALU_OP_DECREMENT_MEMORY: begin
        res.value  = mem_i - mcualu_pkg::MCUALU_ONE;
        res.to_mem = 1'b1;
        res.set_z  = 1'b1;
      end
      mcualu_pkg::MCUALU_OP_DECREMENT_TO_ACCUMULATOR: begin
        res.value  = mem_i - mcualu_pkg::MCUALU_ONE;
        res.to_acc = 1'b1;
        res.set_z  = 1'b1;
      end
      mcualu_pkg::MCUALU_OP_INCREMENT_MEMORY: begin
        res.value  = mem_i + mcualu_pkg::MCUALU_ONE;
        res.to_mem = 1'b1;
        res.set_z  = 1'b1;
      end
      mcualu_pkg::MCUALU_OP_INCREMENT_TO_ACCUMULATOR: begin
        res.value  = mem_i + mcualu_pkg::MCUALU_ONE;
        res.to_acc = 1'b1;
        res.set_z  = 1'b1;
      end
      default: begin
        res.value  = mem_i;
      end
    endcase
  end

  assign res.z = (res.value == 8'h00);

endmodule // mcualu_calc

// ===== verilog/mcualu_top.sv
/*
  Execution datapath for complement, decimal adjust, increment, decrement
  and halt. Holds accumulator, zero, carry and status flags.
  Assumes the decoder presents one operation per cycle with op_valid_i, the
  memory byte on mem_rdata_i, and that memory accepts mem_we_o writes.
  Wake-up from power-down is a plain input pulse from outside.
  Watchdog expiry is a plain input pulse that sets the time-out flag.
*/
`timescale 1ns/10ps
module mcualu_top (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       op_valid_i,
  input  wire logic [2:0] op_i,
  input  wire logic [7:0] mem_rdata_i,
  input  wire logic       ac_i,
  input  wire logic       wake_i,
  input  wire logic       watchdog_expire_i,
  output logic [7:0]      acc_o,
  output logic            zero_o,
  output logic            carry_o,
  output logic            mem_we_o,
  output logic [7:0]      mem_wdata_o,
  output logic            power_down_flag_o,
  output logic            watchdog_timeout_flag_o,
  output logic            watchdog_clear_o,
  output logic            fetch_enable_o,
  output logic            sys_clk_en_o
);

  // -------------------------------------------------------------
  // arithmetic
  // -------------------------------------------------------------
  mcualu_res_if res_w ();
  mcualu_pkg::mcualu_op_e op_w;
  mcualu_pkg::mcualu_st_e st_q;
  mcualu_pkg::mcualu_st_e st_d;
  logic                   take;

  assign op_w = mcualu_pkg::mcualu_op_e'(op_i);
  assign take = op_valid_i && (st_q == mcualu_pkg::MCUALU_ST_RUN);

  mcualu_calc u_calc (
    .op_i  (op_w),
    .mem_i (mem_rdata_i),
    .acc_i (acc_o),
    .c_i   (carry_o),
    .ac_i  (ac_i),
    .res   (res_w)
  );

  // -------------------------------------------------------------
  // registers and flags
  // -------------------------------------------------------------
  logic [7:0] acc_d;
  logic       z_d;
  logic       c_d;
  logic       we_d;
  logic [7:0] wd_d;
  logic       pdf_d;
  logic       to_d;
  logic       wdc_d;

  // next values of datapath state
  always_comb begin
    acc_d = acc_o;
    z_d   = zero_o;
    c_d   = carry_o;
    we_d  = 1'b0;
    wd_d  = mem_wdata_o;
    pdf_d = power_down_flag_o;
    to_d  = watchdog_timeout_flag_o;
    wdc_d = 1'b0;
    st_d  = st_q;
    case (st_q)
      mcualu_pkg::MCUALU_ST_RUN: begin
        if (take) begin
          if (res_w.to_acc) begin
            acc_d = res_w.value;
          end
          if (res_w.to_mem) begin
            we_d = 1'b1;
            wd_d = res_w.value;
          end
          if (res_w.set_z) begin
            z_d = res_w.z;
          end
          if (res_w.set_c) begin
            c_d = res_w.c;
          end
          if (op_w == mcualu_pkg::MCUALU_OP_HALT) begin
            st_d  = mcualu_pkg::MCUALU_ST_DOWN;
            wdc_d = 1'b1;
            pdf_d = 1'b1;
            to_d  = 1'b0;
          end
        end
      end
      mcualu_pkg::MCUALU_ST_DOWN: begin
        if (wake_i) begin
          st_d = mcualu_pkg::MCUALU_ST_RUN;
        end
      end
      default: begin
        st_d = mcualu_pkg::MCUALU_ST_RUN;
      end
    endcase
    if (watchdog_expire_i) begin
      to_d = 1'b1;                     // set beats a halt clear in one cycle
    end
  end

  // register stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q                    <= mcualu_pkg::MCUALU_ST_RUN;
      acc_o                   <= mcualu_pkg::MCUALU_ACC_RST;
      zero_o                  <= mcualu_pkg::MCUALU_FLAG_RST;
      carry_o                 <= mcualu_pkg::MCUALU_FLAG_RST;
      mem_we_o                <= 1'b0;
      mem_wdata_o             <= mcualu_pkg::MCUALU_ACC_RST;
      power_down_flag_o       <= mcualu_pkg::MCUALU_FLAG_RST;
      watchdog_timeout_flag_o <= mcualu_pkg::MCUALU_FLAG_RST;
      watchdog_clear_o        <= 1'b0;
    end else begin
      st_q                    <= st_d;
      acc_o                   <= acc_d;
      zero_o                  <= z_d;
      carry_o                 <= c_d;
      mem_we_o                <= we_d;
      mem_wdata_o             <= wd_d;
      power_down_flag_o       <= pdf_d;
      watchdog_timeout_flag_o <= to_d;
      watchdog_clear_o        <= wdc_d;
    end
  end

  assign fetch_enable_o = (st_q == mcualu_pkg::MCUALU_ST_RUN);
  assign sys_clk_en_o   = (st_q == mcualu_pkg::MCUALU_ST_RUN);

endmodule // mcualu_top

// ===== tb/mcualu_top_props.sv
/* Checker on the datapath top ports.
   Assumes it is bound into every instance of the datapath top. */
`timescale 1ns/10ps
module mcualu_top_props (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       op_valid_i,
  input wire logic [2:0] op_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic       ac_i,
  input wire logic       wake_i,
  input wire logic       watchdog_expire_i,
  input wire logic [7:0] acc_o,
  input wire logic       zero_o,
  input wire logic       carry_o,
  input wire logic       mem_we_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic       power_down_flag_o,
  input wire logic       watchdog_timeout_flag_o,
  input wire logic       watchdog_clear_o,
  input wire logic       fetch_enable_o,
  input wire logic       sys_clk_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // an op is taken only while running
  wire go = op_valid_i && fetch_enable_o;
  sequence s_halt;
    go && op_i == 3'h7 && !watchdog_expire_i;
  endsequence
  sequence s_down;
    power_down_flag_o && !watchdog_timeout_flag_o && watchdog_clear_o && !fetch_enable_o && !sys_clk_en_o;
  endsequence
  AST_CPL: assert property (go && op_i == 3'h1 |=> acc_o == ~$past(mem_rdata_i) && zero_o == (acc_o == 8'h00))
    else $error("complement result wrong");
  AST_DAA_KEEP: assert property (go && op_i == 3'h2 |=> $stable(acc_o) && $stable(zero_o) && mem_we_o)
    else $error("decimal adjust touched accumulator or zero");
  AST_DAA_LO: assert property (go && op_i == 3'h2 && !ac_i && acc_o[3:0] <= 4'h9 |=> mem_wdata_o[3:0] == acc_o[3:0])
    else $error("decimal adjust changed a valid low digit");
  AST_DAA_LO_FIX: assert property (go && op_i == 3'h2 && (ac_i || acc_o[3:0] > 4'h9) |=> mem_wdata_o[3:0] == acc_o[3:0] + 4'h6)
    else $error("decimal adjust missed the low digit fix");
  AST_DAA_HI: assert property (go && op_i == 3'h2 && (acc_o[7:4] > 4'h9 || carry_o) |=> carry_o)
    else $error("decimal adjust lost carry");
  AST_DEC_MEM: assert property (go && op_i == 3'h3 |=> mem_we_o && mem_wdata_o == $past(mem_rdata_i) - 8'h01)
    else $error("decrement write-back wrong");
  AST_DECREMENT_TO_ACCUMULATOR: assert property (go && op_i == 3'h4 |=> !mem_we_o && acc_o == $past(mem_rdata_i) - 8'h01)
    else $error("decrement to accumulator wrong");
  AST_INC_MEM: assert property (go && op_i == 3'h5 |=> mem_we_o && mem_wdata_o == $past(mem_rdata_i) + 8'h01)
    else $error("increment write-back wrong");
  AST_INCREMENT_TO_ACCUMULATOR: assert property (go && op_i == 3'h6 |=> !mem_we_o && acc_o == $past(mem_rdata_i) + 8'h01)
    else $error("increment to accumulator wrong");
  AST_HALT: assert property (s_halt |=> s_down)
    else $error("halt did not enter power-down");
  AST_DOWN_HOLD: assert property (!fetch_enable_o && !wake_i |=> $stable(acc_o) && $stable(carry_o) && !mem_we_o)
    else $error("state changed in power-down");
  AST_CARRY_KEEP: assert property (go && op_i >= 3'h3 && op_i <= 3'h6 |=> $stable(carry_o))
    else $error("increment or decrement touched carry");
  AST_TO_SET: assert property (watchdog_expire_i |=> watchdog_timeout_flag_o)
    else $error("watchdog expiry did not set the time-out flag");
endmodule // mcualu_top_props
bind mcualu_top mcualu_top_props u_props (.clk_i, .rstn_i, .op_valid_i, .op_i, .mem_rdata_i, .ac_i, .wake_i,
  .acc_o, .zero_o, .carry_o, .mem_we_o, .mem_wdata_o, .power_down_flag_o, .watchdog_timeout_flag_o,
  .watchdog_clear_o, .fetch_enable_o, .sys_clk_en_o, .watchdog_expire_i);

// ===== tb/mcualu_mem_model.sv
/* One-byte data memory standing for the addressed location.
   Assumes the bench presents each fresh byte with load_i. */
`timescale 1ns/10ps
module mcualu_mem_model (
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  output logic [7:0]      rdata_o
);
  logic [7:0] mem_q;
  // write-back storage
  // a fresh load stands for a new address, so it replaces a late write-back
  always @(posedge clk_i) begin
    if (load_i) mem_q <= load_data_i;
    else if (we_i) mem_q <= wdata_i;
  end
  // a load is seen by the op in its own cycle
  assign rdata_o = load_i ? load_data_i : mem_q;
endmodule // mcualu_mem_model

// ===== tb/mcualu_top_tb.sv
/* Self-checking bench for the datapath top.
   Assumes the checker binds itself and the memory model serves the byte. */
`timescale 1ns/10ps
module mcualu_top_tb;
  typedef struct packed {logic [7:0] acc; logic z; logic c; logic we; logic [7:0] wd;
    logic power_down_flag; logic to; logic fe; logic wdc;} mcualu_note_s;
  logic clk_i = 0, rstn_i = 0, op_valid_i = 0, ac_i = 0, wake_i = 0, load = 0;
  logic watchdog_expire_i = 0, wx = 0, to_r;
  logic zero_o, carry_o, mem_we_o, power_down_flag_o, watchdog_timeout_flag_o, watchdog_clear_o;
  logic fetch_enable_o, sys_clk_en_o, z_r, c_r, pdf_r, fe_r;
  logic [2:0] op_i = 3'h0;
  logic [7:0] load_data = 8'h00, mem_rdata_i, acc_o, mem_wdata_o, acc_r, mem_ref;
  logic [31:0] v;
  int n_fail = 0, n_tests = 0, seed = 32'h48BD;
  mcualu_note_s q[$];
  mcualu_note_s nt;
  mcualu_top dut (.clk_i, .rstn_i, .op_valid_i, .op_i, .mem_rdata_i, .ac_i, .wake_i, .acc_o, .zero_o, .carry_o,
    .mem_we_o, .mem_wdata_o, .power_down_flag_o, .watchdog_timeout_flag_o, .watchdog_clear_o,
    .fetch_enable_o, .sys_clk_en_o, .watchdog_expire_i);
  mcualu_mem_model u_mem (.clk_i, .we_i(mem_we_o), .wdata_i(mem_wdata_o), .load_i(load),
    .load_data_i(load_data), .rdata_o(mem_rdata_i));
  always #5 clk_i = ~clk_i;
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // drive one op at the falling edge and note what it must give
  task do_op(input logic [2:0] op, input logic ld, input logic [7:0] d, input logic ac);
    logic [8:0] t;
    logic hi;
    logic we;
    logic wdc;
    logic [7:0] wd;
    @(negedge clk_i);
    op_valid_i = 1;
    op_i = op;
    load = ld;
    load_data = d;
    ac_i = ac;
    watchdog_expire_i = wx;
    if (ld) mem_ref = d;
    we = 0;
    wdc = 0;
    wd = 8'h00;
    if (fe_r) case (op)
      3'h1: acc_r = ~mem_ref;
      3'h2: begin
        t = {1'b0, acc_r};
        if (acc_r[3:0] > 4'h9 || ac) t = t + 9'h006;
        hi = t[7:4] > 4'h9 || c_r || t[8];
        if (hi) t = t + 9'h060;
        c_r = c_r | hi | t[8];
        wd = t[7:0];
        we = 1;
      end
      3'h3: begin wd = mem_ref - 8'h01; we = 1; end
      3'h4: acc_r = mem_ref - 8'h01;
      3'h5: begin wd = mem_ref + 8'h01; we = 1; end
      3'h6: acc_r = mem_ref + 8'h01;
      3'h7: begin pdf_r = 1; to_r = 0; fe_r = 0; wdc = 1; end
      default: ;
    endcase
    if (fe_r && op != 3'h0 && op != 3'h2) z_r = (op == 3'h3 || op == 3'h5) ? wd == 8'h00 : acc_r == 8'h00;
    if (we) mem_ref = wd;
    if (wx) to_r = 1;
    q.push_back({acc_r, z_r, c_r, we, wd, pdf_r, to_r, fe_r, wdc});
  endtask
  // compare the oldest note just after the clock edge of each valid op
  always @(posedge clk_i) begin
    if (rstn_i && op_valid_i) begin
      #1;
      nt = q.pop_front();
      chk("acc", nt.acc, acc_o);
      chk("zero", {7'h00, nt.z}, {7'h00, zero_o});
      chk("carry", {7'h00, nt.c}, {7'h00, carry_o});
      chk("mem_we", {7'h00, nt.we}, {7'h00, mem_we_o});
      if (nt.we) chk("mem_wdata", nt.wd, mem_wdata_o);
      chk("pdf", {7'h00, nt.power_down_flag}, {7'h00, power_down_flag_o});
      chk("timeout", {7'h00, nt.to}, {7'h00, watchdog_timeout_flag_o});
      chk("fetch", {7'h00, nt.fe}, {7'h00, fetch_enable_o});
      chk("clk_en", {7'h00, nt.fe}, {7'h00, sys_clk_en_o});
      chk("wd_clear", {7'h00, nt.wdc}, {7'h00, watchdog_clear_o});
    end
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict;
  end
  initial begin
    {acc_r, z_r, c_r, pdf_r, fe_r, mem_ref} = {8'h00, 4'h1, 8'h00};
    to_r = 0;
    repeat (12) @(negedge clk_i);
    rstn_i = 1;
    do_op(3'h6, 1, 8'hFF, 0);
    do_op(3'h4, 1, 8'h00, 0);
    do_op(3'h1, 1, 8'hFF, 0);
    do_op(3'h3, 1, 8'h01, 0);
    do_op(3'h5, 1, 8'hFF, 0);
    do_op(3'h0, 0, 8'h00, 0);
    do_op(3'h6, 0, 8'h00, 0);
    do_op(3'h6, 1, 8'h11, 0);
    do_op(3'h2, 0, 8'h00, 0);
    do_op(3'h2, 0, 8'h00, 1);
    do_op(3'h6, 1, 8'h3A, 0);
    do_op(3'h2, 0, 8'h00, 0);
    do_op(3'h6, 1, 8'h99, 0);
    do_op(3'h2, 0, 8'h00, 0);
    do_op(3'h2, 0, 8'h00, 0);
    for (int i = 0; i < 200; i++) begin
      v = $random(seed);
      wx = v[17] & v[18];
      do_op(3'h1 + 3'(v[7:0] % 6), 1, v[15:8], v[16]);
    end
    wx = 1;
    do_op(3'h6, 1, 8'h20, 0);
    wx = 0;
    do_op(3'h7, 1, 8'h5A, 0);
    do_op(3'h5, 1, 8'h10, 0);
    @(negedge clk_i);
    op_valid_i = 0;
    wake_i = 1;
    @(negedge clk_i);
    wake_i = 0;
    fe_r = 1;
    do_op(3'h6, 1, 8'h41, 0);
    @(negedge clk_i);
    op_valid_i = 0;
    @(negedge clk_i);
    give_verdict;
  end
endmodule // mcualu_top_tb
